// *** rtl/swdr_pkg.sv ***
// Purpose: shared constants for the sleep watchdog and refresh block
// Assumes: 32-bit AXI4-Lite register access, word aligned
// Notes:   register offsets are byte addresses
package swdr_pkg;
	// ****************************************
	// bus
	// ****************************************
	localparam int         AXI_AW        = 8;
	localparam int         AXI_DW        = 32;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_SLEEP_CFG = 8'h04;
	localparam logic [7:0] REG_WD_CLEAR  = 8'h08;
	localparam logic [7:0] REG_STATUS    = 8'h0C;
	localparam logic [7:0] REG_ST_COUNT  = 8'h10;
	// ****************************************
	// fields and reset values
	// ****************************************
	localparam int         CFG_OSC_OFF   = 0;
	localparam int         CFG_ALT_LSB   = 2;
	localparam int         CFG_DUTY_LSB  = 6;
	localparam logic [1:0] DUTY_RESET    = 2'h0;
	localparam logic [1:0] ALT_RESET     = 2'h0;
	localparam logic       OSC_OFF_RESET = 1'b0;
	localparam logic [1:0] SYNC_RESET    = 2'h2;
	// ****************************************
	// counts
	// ****************************************
	localparam int          ST_W         = 10;
	localparam int          RF_W         = 15;
	localparam logic [10:0] ST_COUNTS_00 = 11'h100;
	localparam logic [10:0] ST_COUNTS_01 = 11'h400;
	localparam logic [10:0] ST_COUNTS_10 = 11'h040;
	localparam logic [10:0] ST_COUNTS_11 = 11'h010;
	localparam logic [15:0] RF_COUNTS_01 = 16'h8000;
	localparam logic [15:0] RF_COUNTS_10 = 16'h2000;
	localparam logic [1:0]  ALT_32K      = 2'h1;
	localparam logic [1:0]  ALT_8K       = 2'h2;
	localparam logic [1:0]  WD_TERMINAL  = 2'h3;
	localparam logic [7:0]  WD_CLEAR_ALL = 8'h38;
endpackage : swdr_pkg

// *** rtl/swdr_regs_if.sv ***
// Purpose: register access strobes between bus slave and core
// Assumes: single clock, wr_en is a one-cycle pulse
// Notes:   rd_data and errors are combinational from the core
interface swdr_regs_if;
	import swdr_pkg::*;
	logic              wr_en;
	logic [AXI_AW-1:0] wr_addr;
	logic [AXI_DW-1:0] wr_data;
	logic [3:0]        wr_strb;
	logic              wr_err;
	logic [AXI_AW-1:0] rd_addr;
	logic [AXI_DW-1:0] rd_data;
	logic              rd_err;
	modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
	              input  wr_err, rd_data, rd_err);
	modport core (input  wr_en, wr_addr, wr_data, wr_strb, rd_addr,
	              output wr_err, rd_data, rd_err);
endinterface : swdr_regs_if

// *** rtl/swdr_axil.sv ***
// Purpose: AXI4-Lite slave front end for the watchdog registers
// Assumes: one write and one read outstanding at most
// Notes:   address and data accepted in either order
module swdr_axil
	import swdr_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic [AXI_AW-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [AXI_DW-1:0] s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [AXI_AW-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [AXI_DW-1:0]      s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	swdr_regs_if.bus               rif
);
	// ****************************************
	// write channel
	// ****************************************
	logic              aw_held_reg;
	logic              w_held_reg;
	logic [AXI_AW-1:0] aw_addr_reg;
	logic [AXI_DW-1:0] w_data_reg;
	logic [3:0]        w_strb_reg;
	wire aw_take   = s_axi_awvalid & s_axi_awready;
	wire w_take    = s_axi_wvalid & s_axi_wready;
	wire aw_have   = aw_held_reg | aw_take;
	wire w_have    = w_held_reg | w_take;
	wire do_wr     = aw_have & w_have & ~s_axi_bvalid;
	wire aw_next   = aw_have & ~do_wr;
	wire w_next    = w_have & ~do_wr;
	wire b_next    = do_wr | (s_axi_bvalid & ~s_axi_bready);
	assign rif.wr_en   = do_wr;
	assign rif.wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
	assign rif.wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
	assign rif.wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_held_reg   <= 1'b0;
			w_held_reg    <= 1'b0;
			aw_addr_reg   <= '0;
			w_data_reg    <= '0;
			w_strb_reg    <= '0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			aw_held_reg   <= aw_next;
			w_held_reg    <= w_next;
			if (aw_take) aw_addr_reg <= s_axi_awaddr;
			if (w_take) begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			s_axi_awready <= ~aw_next & ~b_next;
			s_axi_wready  <= ~w_next & ~b_next;
			s_axi_bvalid  <= b_next;
			if (do_wr) s_axi_bresp <= rif.wr_err ? RESP_SLVERR : RESP_OKAY;
		end
	end
	// ****************************************
	// read channel
	// ****************************************
	wire ar_take = s_axi_arvalid & s_axi_arready;
	wire r_next  = ar_take | (s_axi_rvalid & ~s_axi_rready);
	assign rif.rd_addr = s_axi_araddr;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= ~r_next;
			s_axi_rvalid  <= r_next;
			if (ar_take) begin
				s_axi_rdata <= rif.rd_data;
				s_axi_rresp <= rif.rd_err ? RESP_SLVERR : RESP_OKAY;
			end
		end
	end
endmodule : swdr_axil

// *** rtl/swdr_top.sv ***
// Purpose: sleep timer driven watchdog with bandgap refresh pacing
// Assumes: slow clock and external reset arrive as asynchronous pins
// Notes:   system_reset covers watchdog and external reset sources
//
// Summary of operation
// R1: in sleep, refresh reference and comparators paced by slow clock and duty field
// R2: duty field picks sleep period: 256, 1024, 64 or 16 slow counts
// R3: duty field paces refresh only while alternate buzz rate is 00; code also uses the duty field at rate 11
// R4: in sleep, bandgap and low voltage detect are off outside refresh
// R5: when awake, bandgap output drives reference directly
// R6: power-on or external reset disables watchdog and sets power-on flag
// R7: clearing power-on flag enables watchdog for good; software cannot set it
// R8: only power-on or external reset disables an enabled watchdog
// R9: counter steps on each sleep interrupt; terminal count at three
// R10: terminal count sampled on slow falling edge, reset held one slow cycle
// R11: terminal count flop ignores its own reset, cleared by all others
// R12: any write to the clear register clears the watchdog counter
// R13: writing 38h also clears the sleep timer
// R14: watchdog reset acts as full system reset of all registers; code leaves power-on flag and terminal count flop unchanged and sets last-reset flag
// R15: with ram init disabled, watchdog reset keeps SRAM contents
// R16: clearing mid-interval gives timeout between two and three intervals
// R17: software must clear the watchdog within each interval
// R18: watchdog stays enabled after a watchdog reset
// R19: alternate rate: 00 duty field, 01 1/32768, 10 1/8192, 11 reserved
// R20: slow oscillator off in sleep halts timer, watchdog and buzzing
// R21: counter advances once per interrupt pulse by edge detection
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
module swdr_top
	import swdr_pkg::*;
#(
	parameter int BUZZ_W           = 4,
	parameter int BUZZ_SLOW_CYCLES = 1
)(
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic              external_reset_pin_n,
	input  wire logic              slow_clk_pin,
	input  wire logic              sleep_active,
	input  wire logic              ram_init_disable,
	input  wire logic [AXI_AW-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [AXI_DW-1:0] s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [AXI_AW-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [AXI_DW-1:0]      s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic                   sleep_timer_irq,
	output logic                   watchdog_reset,
	output logic                   system_reset,
	output logic                   sram_init_enable,
	output logic                   bandgap_enable,
	output logic                   low_voltage_detect,
	output logic                   vref_direct,
	output logic                   slow_osc_enable
);
	// ****************************************
	// register bus
	// ****************************************
	swdr_regs_if rif ();

	swdr_axil u_axil (
		.clk           (clk),
		.reset_n       (reset_n),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.rif           (rif)
	);

	// ****************************************
	// pin synchronisers
	// ****************************************
	// bit 0 slow clock, bit 1 external reset pin (low active)
	logic [1:0] sy1_reg;
	logic [1:0] sy2_reg;
	logic [1:0] sy3_reg;
	logic [1:0] lvl_reg;
	wire  [1:0] pin_raw  = {external_reset_pin_n, slow_clk_pin};
	wire  [1:0] agree    = ~(sy2_reg ^ sy3_reg);
	wire  [1:0] lvl_next = (agree & sy3_reg) | (~agree & lvl_reg);
	wire  [1:0] lvl_rise = lvl_next & ~lvl_reg;
	wire  [1:0] lvl_fall = ~lvl_next & lvl_reg;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sy1_reg <= SYNC_RESET;
			sy2_reg <= SYNC_RESET;
			sy3_reg <= SYNC_RESET;
			lvl_reg <= SYNC_RESET;
		end else begin
			sy1_reg <= pin_raw;
			sy2_reg <= sy1_reg;
			sy3_reg <= sy2_reg;
			lvl_reg <= lvl_next;
		end
	end

	// ****************************************
	// configuration and reset sources
	// ****************************************
	logic [1:0] duty_sel_reg;
	logic [1:0] alt_rate_reg;
	logic       osc_off_reg;
	logic       por_flag_reg;
	logic       wdog_reg;
	logic       last_wdog_reg;

	wire pin_rst  = ~lvl_reg[1];
	// watchdog and external reset both reinitialise the block
	wire sys_rst  = wdog_reg | pin_rst; // R14
	wire osc_run  = ~(sleep_active & osc_off_reg); // R20
	wire tick_r   = lvl_rise[0] & osc_run; // R1
	wire slow_f   = lvl_fall[0];

	// ****************************************
	// register decode
	// ****************************************
	wire [AXI_AW-1:0] wr_word = {rif.wr_addr[AXI_AW-1:2], 2'b00};
	wire [AXI_AW-1:0] rd_word = {rif.rd_addr[AXI_AW-1:2], 2'b00};
	wire wr_ctrl  = rif.wr_en & (wr_word == REG_CTRL);
	wire wr_cfg   = rif.wr_en & (wr_word == REG_SLEEP_CFG);
	wire wr_clr   = rif.wr_en & (wr_word == REG_WD_CLEAR);
	wire wr_ro    = (wr_word == REG_STATUS) | (wr_word == REG_ST_COUNT);
	wire lane0    = rif.wr_strb[0];
	wire wd_clr   = wr_clr; // R12
	wire st_clr   = wr_clr & lane0 & (rif.wr_data[7:0] == WD_CLEAR_ALL); // R13
	wire por_wclr = wr_ctrl & lane0 & ~rif.wr_data[0]; // R7

	assign rif.wr_err = ~(wr_ctrl | wr_cfg | wr_clr | (rif.wr_en & wr_ro));

	// ****************************************
	// configuration registers
	// ****************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			duty_sel_reg <= DUTY_RESET;
			alt_rate_reg <= ALT_RESET;
			osc_off_reg  <= OSC_OFF_RESET;
		end else if (sys_rst) begin
			duty_sel_reg <= DUTY_RESET; // R14
			alt_rate_reg <= ALT_RESET;
			osc_off_reg  <= OSC_OFF_RESET;
		end else if (wr_cfg && lane0) begin
			duty_sel_reg <= rif.wr_data[CFG_DUTY_LSB +: 2];
			alt_rate_reg <= rif.wr_data[CFG_ALT_LSB +: 2];
			osc_off_reg  <= rif.wr_data[CFG_OSC_OFF];
		end
	end

	// power-on flag: set by power-on or external reset, software clears only
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			por_flag_reg <= 1'b1; // R6
		end else if (pin_rst) begin
			por_flag_reg <= 1'b1; // R8
		end else if (por_wclr) begin
			por_flag_reg <= 1'b0; // R7
		end
	end

	// survives watchdog reset, so enable holds through init code
	wire wd_en = ~por_flag_reg; // R18

	// ****************************************
	// sleep timer
	// ****************************************
	logic [ST_W-1:0] st_cnt_reg;
	logic            st_irq_reg;
	logic            st_irq_d_reg;
	wire  [10:0]     st_counts = (duty_sel_reg == 2'h0) ? ST_COUNTS_00 :
	                             (duty_sel_reg == 2'h1) ? ST_COUNTS_01 :
	                             (duty_sel_reg == 2'h2) ? ST_COUNTS_10 :
	                             ST_COUNTS_11; // R2
	wire  [10:0]     st_last_w = st_counts - 11'h001;
	wire  [ST_W-1:0] st_last   = st_last_w[ST_W-1:0];
	wire             st_wrap   = tick_r & (st_cnt_reg >= st_last);
	wire  [ST_W-1:0] st_inc    = st_cnt_reg + 10'h001;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_cnt_reg <= '0;
		end else if (sys_rst || st_clr) begin
			st_cnt_reg <= '0; // R13
		end else if (tick_r) begin
			st_cnt_reg <= st_wrap ? '0 : st_inc;
		end
	end

	// interrupt stands for one slow cycle; a new wrap wins over the clear
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_irq_reg   <= 1'b0;
			st_irq_d_reg <= 1'b0;
		end else begin
			st_irq_reg   <= ~sys_rst & (st_wrap | (st_irq_reg & ~tick_r));
			st_irq_d_reg <= st_irq_reg;
		end
	end

	assign sleep_timer_irq = st_irq_reg;

	// ****************************************
	// watchdog counter
	// ****************************************
	logic [1:0] wd_cnt_reg;
	wire        irq_edge = st_irq_reg & ~st_irq_d_reg; // R21
	wire        wd_step  = irq_edge & wd_en;
	wire [1:0]  wd_base  = wd_clr ? 2'h0 : wd_cnt_reg;
	wire        wd_sat   = (wd_base == WD_TERMINAL);
	wire [1:0]  wd_inc   = wd_base + 2'h1;
	wire        wd_tc    = wd_en & (wd_cnt_reg == WD_TERMINAL); // R9

	// a clear that meets a step leaves count 1: the step is kept
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wd_cnt_reg <= '0;
		end else if (sys_rst) begin
			wd_cnt_reg <= '0;
		end else if (wd_step && !wd_sat) begin
			wd_cnt_reg <= wd_inc; // R9
		end else begin
			wd_cnt_reg <= wd_base; // R16
		end
	end

	// terminal count flop: own reset does not clear it
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wdog_reg <= 1'b0; // R11
		end else if (pin_rst) begin
			wdog_reg <= 1'b0; // R11
		end else if (slow_f) begin
			wdog_reg <= wd_tc; // R10
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			last_wdog_reg <= 1'b0;
		end else if (pin_rst) begin
			last_wdog_reg <= 1'b0;
		end else if (wdog_reg) begin
			last_wdog_reg <= 1'b1;
		end
	end

	// ****************************************
	// refresh pacing
	// ****************************************
	logic [RF_W-1:0]   rf_cnt_reg;
	logic [BUZZ_W-1:0] buzz_cnt_reg;
	wire               alt_own  = (alt_rate_reg == ALT_32K) |
	                              (alt_rate_reg == ALT_8K); // R19
	wire  [15:0]       rf_cnts  = (alt_rate_reg == ALT_32K) ? RF_COUNTS_01 : RF_COUNTS_10;
	wire  [15:0]       rf_last_w = rf_cnts - 16'h0001;
	wire  [RF_W-1:0]   rf_last  = rf_last_w[RF_W-1:0];
	wire               rf_wrap  = tick_r & (rf_cnt_reg >= rf_last);
	wire  [RF_W-1:0]   rf_inc   = rf_cnt_reg + 15'h0001;
	wire               rf_hit   = alt_own ? rf_wrap : st_wrap; // R3
	wire               buzz_on  = (buzz_cnt_reg != '0);
	wire  [BUZZ_W-1:0] buzz_ld  = BUZZ_W'(BUZZ_SLOW_CYCLES);
	wire  [BUZZ_W-1:0] buzz_dec = buzz_cnt_reg - 1'b1;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rf_cnt_reg <= '0;
		end else if (sys_rst || !sleep_active || !alt_own) begin
			rf_cnt_reg <= '0;
		end else if (tick_r) begin
			rf_cnt_reg <= rf_wrap ? '0 : rf_inc; // R19
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			buzz_cnt_reg <= '0;
		end else if (sys_rst || !sleep_active) begin
			buzz_cnt_reg <= '0;
		end else if (rf_hit) begin
			buzz_cnt_reg <= buzz_ld; // R1
		end else if (tick_r && buzz_on) begin
			buzz_cnt_reg <= buzz_dec;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bandgap_enable     <= 1'b1;
			low_voltage_detect <= 1'b1;
			vref_direct        <= 1'b1;
			slow_osc_enable    <= 1'b1;
			system_reset       <= 1'b0;
			sram_init_enable   <= 1'b1;
		end else begin
			bandgap_enable     <= ~sleep_active | buzz_on; // R4
			low_voltage_detect <= ~sleep_active | buzz_on; // R4
			vref_direct        <= ~sleep_active; // R5
			slow_osc_enable    <= osc_run; // R20
			system_reset       <= sys_rst; // R14
			sram_init_enable   <= ~(wdog_reg & ram_init_disable); // R15
		end
	end

	assign watchdog_reset = wdog_reg; // R10

	// ****************************************
	// read back
	// ****************************************
	wire rd_ctrl = (rd_word == REG_CTRL);
	wire rd_cfg  = (rd_word == REG_SLEEP_CFG);
	wire rd_clr  = (rd_word == REG_WD_CLEAR);
	wire rd_stat = (rd_word == REG_STATUS);
	wire rd_cnt  = (rd_word == REG_ST_COUNT);

	wire [AXI_DW-1:0] ctrl_word = {31'h0000_0000, por_flag_reg};
	wire [AXI_DW-1:0] cfg_word  = {24'h00_0000, duty_sel_reg, 2'b00,
	                               alt_rate_reg, 1'b0, osc_off_reg};
	wire [AXI_DW-1:0] stat_word = {25'h000_0000, buzz_on, st_irq_reg,
	                               last_wdog_reg, wd_en, wd_tc, wd_cnt_reg};
	wire [AXI_DW-1:0] cnt_word  = {22'h00_0000, st_cnt_reg};

	assign rif.rd_data = ({AXI_DW{rd_ctrl}} & ctrl_word) |
	                     ({AXI_DW{rd_cfg}}  & cfg_word)  |
	                     ({AXI_DW{rd_stat}} & stat_word) |
	                     ({AXI_DW{rd_cnt}}  & cnt_word);
	assign rif.rd_err  = ~(rd_ctrl | rd_cfg | rd_clr | rd_stat | rd_cnt);
endmodule : swdr_top

// *** sim/swdr_top_properties.sv ***
// Purpose: concurrent checks on the watchdog block top ports
// Assumes: one clock domain, reset_n active low
// Notes:   bound to every swdr_top instance
module swdr_top_chk (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic sleep_active,
	input wire logic ram_init_disable,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic watchdog_reset,
	input wire logic system_reset,
	input wire logic sram_init_enable,
	input wire logic bandgap_enable,
	input wire logic low_voltage_detect,
	input wire logic vref_direct,
	input wire logic slow_osc_enable
);
	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	chk_vref_awake_direct: assert property (!sleep_active ##1 !sleep_active |-> vref_direct)
		else $error("vref not direct while awake");
	chk_bandgap_awake_on: assert property (!sleep_active ##1 !sleep_active |-> bandgap_enable)
		else $error("bandgap off while awake");
	chk_detect_follows_bg: assert property (bandgap_enable == low_voltage_detect)
		else $error("detector power differs from bandgap");
	chk_wdog_held: assert property ($rose(watchdog_reset) |-> watchdog_reset [*8])
		else $error("watchdog reset too short");
	chk_wdog_sys_reset: assert property (watchdog_reset |=> system_reset)
		else $error("watchdog reset not seen as system reset");
	chk_sram_kept: assert property (watchdog_reset && ram_init_disable |=> !sram_init_enable)
		else $error("sram init not held off");
	chk_sram_init_idle: assert property (!watchdog_reset |=> sram_init_enable)
		else $error("sram init dropped without watchdog reset");
	chk_osc_awake_on: assert property (!sleep_active |=> slow_osc_enable)
		else $error("slow oscillator off while awake");
	chk_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	chk_rresp_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read response repeated");
endmodule : swdr_top_chk

bind swdr_top swdr_top_chk chk_u (.clk(clk), .reset_n(reset_n), .sleep_active(sleep_active),
	.ram_init_disable(ram_init_disable), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.watchdog_reset(watchdog_reset), .system_reset(system_reset),
	.sram_init_enable(sram_init_enable), .bandgap_enable(bandgap_enable),
	.low_voltage_detect(low_voltage_detect), .vref_direct(vref_direct),
	.slow_osc_enable(slow_osc_enable));

// *** sim/tb_top.sv ***
// Purpose: self-checking bench for the sleep watchdog block
// Assumes: slow pin toggles every 6 clocks, duty select 3 for short intervals
// Notes:   bready, rready and wstrb are held constant
module tb_top
	import swdr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic        w;
		logic [7:0]  a;
		logic [31:0] d;
		logic [1:0]  resp;
		logic [15:0] ev;
		logic [15:0] mk;
	} swdr_row_t;
	localparam swdr_row_t ROWS [9] = '{
		'{1'b0, REG_CTRL, 32'h0000_0000, RESP_OKAY, 16'h0001, 16'h0001},
		'{1'b0, REG_SLEEP_CFG, 32'h0000_0000, RESP_OKAY, 16'h0000, 16'h00FF},
		'{1'b1, REG_SLEEP_CFG, 32'h0000_00C0, RESP_OKAY, 16'h0000, 16'h0000},
		'{1'b0, REG_SLEEP_CFG, 32'h0000_0000, RESP_OKAY, 16'h00C0, 16'h00FF},
		'{1'b1, REG_CTRL, 32'h0000_0001, RESP_OKAY, 16'h0000, 16'h0000},
		'{1'b0, REG_CTRL, 32'h0000_0000, RESP_OKAY, 16'h0001, 16'h0001},
		'{1'b0, 8'h14, 32'h0000_0000, RESP_SLVERR, 16'h0000, 16'hFFFF},
		'{1'b1, REG_CTRL, 32'h0000_0000, RESP_OKAY, 16'h0000, 16'h0000},
		'{1'b0, REG_STATUS, 32'h0000_0000, RESP_OKAY, 16'h0008, 16'h0008}
	};
	logic              clk = 1'b0;
	logic              reset_n = 1'b0;
	logic              external_reset_pin_n = 1'b1;
	logic              slow_clk_pin = 1'b0;
	logic              sleep_active = 1'b0;
	logic              ram_init_disable = 1'b0;
	logic [AXI_AW-1:0] s_axi_awaddr = '0;
	logic [AXI_AW-1:0] s_axi_araddr = '0;
	logic [AXI_DW-1:0] s_axi_wdata = '0;
	logic [3:0]        s_axi_wstrb = 4'hF;
	logic              s_axi_awvalid = 1'b0;
	logic              s_axi_wvalid = 1'b0;
	logic              s_axi_arvalid = 1'b0;
	logic              s_axi_bready = 1'b1;
	logic              s_axi_rready = 1'b1;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	logic [AXI_DW-1:0] s_axi_rdata;
	logic              sleep_timer_irq, watchdog_reset, system_reset, sram_init_enable;
	logic              bandgap_enable, low_voltage_detect, vref_direct, slow_osc_enable;
	int                err_total = 0;
	int                checked = 0;

	swdr_top dut_u (.clk, .reset_n, .external_reset_pin_n, .slow_clk_pin, .sleep_active,
		.ram_init_disable, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_timer_irq, .watchdog_reset,
		.system_reset, .sram_init_enable, .bandgap_enable, .low_voltage_detect,
		.vref_direct, .slow_osc_enable);

	// ****************************************
	// clocks and helpers
	// ****************************************
	initial begin
		forever #5 clk = ~clk;
	end
	initial begin
		forever begin
			repeat (6) @(posedge clk);
			slow_clk_pin <= ~slow_clk_pin;
		end
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] ev);
		checked++;
		if (seen !== ev) begin
			$display("MISMATCH %s expected %h seen %h", nm, ev, seen);
			err_total++;
		end
	endtask : check
	task automatic stop(input string nm);
		$display("MISMATCH %s expected done seen timeout", nm);
		err_total++;
		summarize();
	endtask : stop
	task automatic run(input swdr_row_t r);
		int n;
		n = 0;
		if (r.w) begin
			s_axi_awaddr  <= r.a;
			s_axi_wdata   <= r.d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid  <= 1'b1;
		end else begin
			s_axi_araddr  <= r.a;
			s_axi_arvalid <= 1'b1;
		end
		do begin
			@(posedge clk);
			n++;
			if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
			if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
			if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
		end while (!(r.w ? s_axi_bvalid : s_axi_rvalid) && n < 40);
		if (n >= 40) stop("bus");
		check("resp", 32'(r.w ? s_axi_bresp : s_axi_rresp), 32'(r.resp));
		if (!r.w) check("rdata", s_axi_rdata & 32'(r.mk), 32'(r.ev));
	endtask : run
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		run('{1'b1, a, d, RESP_OKAY, 16'h0000, 16'h0000});
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] ev, input logic [15:0] mk);
		run('{1'b0, a, 32'h0000_0000, RESP_OKAY, ev, mk});
	endtask : rd
	task automatic wait_rise(input logic sel, input int lim);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while ((sel ? watchdog_reset : sleep_timer_irq) !== 1'b0 && n < lim);
		do begin
			@(negedge clk);
			n++;
		end while ((sel ? watchdog_reset : sleep_timer_irq) !== 1'b1 && n < lim);
		if (n >= lim) stop(sel ? "watchdog_reset" : "sleep_timer_irq");
		@(posedge clk);
	endtask : wait_rise

	// ****************************************
	// sequence
	// ****************************************
	initial begin
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		foreach (ROWS[i]) run(ROWS[i]);
		$display("register table done");
		ram_init_disable <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			wait_rise(1'b0, 400);
			wr(REG_WD_CLEAR, 32'(i * 85));
		end
		wait_rise(1'b0, 400);
		rd(REG_STATUS, 16'h0001, 16'h0007);
		check("no reset while cleared", 32'(watchdog_reset), 32'h0);
		wait_rise(1'b0, 400);
		repeat (10) @(posedge clk);
		check("no reset at two", 32'(watchdog_reset), 32'h0);
		wait_rise(1'b0, 400);
		wait_rise(1'b1, 40);
		@(negedge clk);
		check("system_reset", 32'(system_reset), 32'h1);
		check("sram_init_enable", 32'(sram_init_enable), 32'h0);
		repeat (30) @(posedge clk);
		ram_init_disable <= 1'b0;
		rd(REG_SLEEP_CFG, 16'h0000, 16'h00FF);
		rd(REG_STATUS, 16'h0018, 16'h0018);
		rd(REG_CTRL, 16'h0000, 16'h0001);
		$display("watchdog expiry done");
		wr(REG_WD_CLEAR, 32'h0000_0038);
		rd(REG_ST_COUNT, 16'h0000, 16'h03FE);
		external_reset_pin_n <= 1'b0;
		repeat (20) @(posedge clk);
		external_reset_pin_n <= 1'b1;
		repeat (20) @(posedge clk);
		rd(REG_CTRL, 16'h0001, 16'h0001);
		rd(REG_STATUS, 16'h0000, 16'h0018);
		$display("clear and external reset done");
		wr(REG_SLEEP_CFG, 32'h0000_0001);
		sleep_active <= 1'b1;
		repeat (5) @(posedge clk);
		@(negedge clk);
		check("vref asleep", 32'(vref_direct), 32'h0);
		check("osc asleep", 32'(slow_osc_enable), 32'h0);
		check("detect asleep", 32'(low_voltage_detect), 32'h0);
		@(posedge clk);
		sleep_active <= 1'b0;
		repeat (3) @(posedge clk);
		@(negedge clk);
		check("bandgap awake", 32'(bandgap_enable), 32'h1);
		check("osc awake", 32'(slow_osc_enable), 32'h1);
		$display("sleep outputs done");
		summarize();
	end
endmodule : tb_top
